// ### dv/bus_grant_clock_reset_sync_checker.sv
`timescale 1ns/10ps
`include "bus_grant_regs.vh"
module bus_grant_clock_reset_sync_checker (
  input wire ref_clk,
  input wire reset_n,
  input wire [`MODE_W-1:0] mode_latched,
  input wire lock_done,
  input wire processor_clock_output,
  input wire [`FL_W-1:0] dedicated_flag_out,
  input wire bus_request_n,
  input wire strobe_oe,
  input wire bus_grant_n,
  input wire bus_grant_hang_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  sequence hand_over; !strobe_oe ##1 !bus_grant_n; endsequence
  sequence hand_back; bus_grant_n ##1 strobe_oe; endsequence
  clk_double_a: assert property ($past(reset_n) |->
    processor_clock_output != $past(processor_clock_output))
    else $error("clock output stalled");
  mode_hold_a: assert property ($past(reset_n, 2) |-> $stable(mode_latched))
    else $error("mode changed");
  req_grant_a: assert property ($fell(bus_request_n) && lock_done |-> ##[5:6] hand_over)
    else $error("grant late");
  strobe_off_a: assert property ($fell(strobe_oe) |-> $rose(processor_clock_output))
    else $error("strobes released off clock output rise");
  req_drop_a: assert property ($rose(bus_request_n) && !bus_grant_n |-> ##[2:5] hand_back)
    else $error("bus not taken back");
  grant_order_a: assert property ($fell(bus_grant_n) |-> $past(!strobe_oe))
    else $error("grant before disable");
  enable_order_a: assert property ($rose(strobe_oe) |-> $past(bus_grant_n))
    else $error("enable before grant high");
  hang_window_a: assert property (!bus_grant_hang_n |-> !bus_grant_n && !strobe_oe)
    else $error("hang outside grant");
  flag_fall_a: assert property (!$stable(dedicated_flag_out) |-> $past(processor_clock_output))
    else $error("flag moved off falling edge");
  lock_wait_a: assert property (!lock_done |-> bus_grant_n && strobe_oe)
    else $error("grant before lock");
endmodule
bind bus_grant_clock_reset_sync bus_grant_clock_reset_sync_checker u_chk (.ref_clk(ref_clk),
  .reset_n(reset_n), .mode_latched(mode_latched), .lock_done(lock_done),
  .processor_clock_output(processor_clock_output), .dedicated_flag_out(dedicated_flag_out),
  .bus_request_n(bus_request_n), .strobe_oe(strobe_oe), .bus_grant_n(bus_grant_n),
  .bus_grant_hang_n(bus_grant_hang_n));

// ### dv/bus_grant_clock_reset_sync_tb.sv
`timescale 1ns/10ps
module bus_grant_clock_reset_sync_tb;
  logic ref_clk = 0, reset_n = 0, go = 0, need = 0;
  logic [7:0] hold = 8'h00;
  logic [3:0] mode = 4'h5;
  logic [5:0] irq = 6'h3f;
  logic [2:0] fl = 3'h0;
  logic [4:0] sel = 5'h1f;
  wire [3:0] mode_q;
  wire [5:0] seen;
  wire [2:0] fl_out;
  wire [4:0] ms_n;
  wire oe, req_n, gnt_n, hang_n;
  wire rd_o, wr_o, fi_seen, fo, stall, lock, clk_out;
  wire [7:0] pf_seen, pf_out, pf_oe;
  int failures = 0, checked = 0;
  always #5 ref_clk = ~ref_clk;
  bus_master_model u_bm (.ref_clk(ref_clk), .go(go), .hold(hold), .bus_grant_n(gnt_n),
    .bus_request_n(req_n));
  bus_grant_clock_reset_sync #(.LOCK_CYCLES(4)) u_dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .mode_select(mode), .mode_latched(mode_q), .lock_done(lock),
    .processor_clock_output(clk_out),
    .external_interrupt_n(irq), .flag_input(irq[0]), .programmable_flag_pin_in({2'b11, irq}),
    .interrupt_seen(seen), .flag_input_seen(fi_seen), .programmable_flag_seen(pf_seen),
    .pf_out_value({5'h00, fl}), .pf_out_drive(8'hff), .fl_value(fl), .flag_output_value(fl[0]),
    .programmable_flag_pin_out(pf_out), .programmable_flag_pin_oe(pf_oe),
    .dedicated_flag_out(fl_out),
    .flag_output(fo), .core_select_n(sel), .core_rd_n(sel[0]), .core_wr_n(sel[1]),
    .core_needs_bus(need), .core_stall(stall), .memory_space_select_n(ms_n), .rd_n(rd_o),
    .wr_n(wr_o),
    .strobe_oe(oe), .bus_request_n(req_n), .bus_grant_n(gnt_n), .bus_grant_hang_n(hang_n));
  task automatic check(string what, logic [7:0] got, logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s exp %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_gnt(input logic v);
    for (int n = 0; n < 40 && gnt_n !== v; n++)
      @(negedge ref_clk);
    check("grant", gnt_n, v);
  endtask
  task automatic test_grant(input logic [7:0] h);
    @(negedge ref_clk);
    hold <= h;
    need <= h[0];
    go <= 1'b1;
    @(negedge ref_clk);
    go <= 1'b0;
    wait_gnt(1'b0);
    check("oe_off", oe, 1'b0);
    check("hang", hang_n, !need);
    wait_gnt(1'b1);
    check("oe_late", oe, 1'b0);
    @(negedge ref_clk);
    check("oe_on", oe, 1'b1);
    $display("grant test hold %0d done", h);
  endtask
  task automatic test_sync;
    logic c;
    check("mode", mode_q, 4'h5);
    irq = 6'h2a;
    fl = 3'h5;
    sel = 5'h0c;
    repeat (4) @(negedge ref_clk);
    check("irq", seen, 6'h15);
    check("flags", fl_out, 3'h5);
    check("select", ms_n, 5'h0c);
    check("fi_seen", fi_seen, 1'b0);
    check("pf_seen", pf_seen, 8'hea);
    check("pf_out", pf_out, 8'h05);
    check("pf_oe", pf_oe, 8'hff);
    check("flag_out", fo, 1'b1);
    check("rd", rd_o, 1'b0);
    check("wr", wr_o, 1'b0);
    check("stall", stall, 1'b0);
    c = clk_out;
    @(negedge ref_clk);
    check("clk_out", clk_out, !c);
    $display("sync test done");
  endtask
  task automatic test_reset;
    mode = 4'h3;
    reset_n = 0;
    repeat (6) @(negedge ref_clk);
    check("rst_grant", gnt_n, 1'b1);
    check("rst_oe", oe, 1'b1);
    check("rst_flags", fl_out, 3'h0);
    check("rst_lock", lock, 1'b0);
    reset_n = 1;
    @(negedge ref_clk);
    mode = 4'hc;
    check("mode_new", mode_q, 4'h3);
    check("stall_lock", stall, 1'b1);
    repeat (12) @(negedge ref_clk);
    check("mode_kept", mode_q, 4'h3);
    check("lock_after", lock, 1'b1);
    check("stall_free", stall, 1'b0);
    $display("reset test done");
  endtask
  task automatic finish_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge ref_clk);
    reset_n = 1;
    @(negedge ref_clk);
    mode = 4'ha;
    test_grant(8'h00);
    test_sync;
    test_reset;
    test_grant(8'h07);
    finish_test;
  end
  initial begin
    #20000;
    failures++;
    finish_test;
  end
endmodule

// ### dv/bus_master_model.sv
`timescale 1ns/10ps
module bus_master_model (
  input wire ref_clk,
  input wire go,
  input wire [7:0] hold,
  input wire bus_grant_n,
  output logic bus_request_n = 1'b1
);
  logic [7:0] cnt_q;
  always @(negedge ref_clk) begin
    if (go && bus_request_n) begin
      bus_request_n <= 1'b0;
      cnt_q <= hold;
    end else if (!bus_grant_n && !bus_request_n) begin
      // keeps asking until its own bus work is over
      if (cnt_q == 8'h00)
        bus_request_n <= 1'b1;
      else
        cnt_q <= cnt_q - 8'h01;
    end
  end
endmodule

// ### src/bus_grant_clock_reset_sync.v
// Behaviour
// - processor cycle is twice input clock rate
// - interrupt and flag inputs sampled synchronously
// - bus request synchronised, recognised four cycles later
// - flag outputs change after clock output falls
// - three-state selects and strobes, then grant
// - drop grant before driving selects again
// - hang asserted only while strobes disabled
`timescale 1ns/10ps
`include "bus_grant_regs.vh"
module bus_grant_clock_reset_sync #(
  parameter LOCK_CYCLES = `LOCK_INPUT_CYCLES
) (
  // clock and reset; ref_clk is the processor cycle clock
  input wire ref_clk,
  input wire reset_n,
  // mode straps
  input wire [`MODE_W-1:0] mode_select,
  output wire [`MODE_W-1:0] mode_latched,
  output wire lock_done,
  // processor clock output
  output wire processor_clock_output,
  // asynchronous inputs
  input wire [`IRQ_W-1:0] external_interrupt_n,
  input wire flag_input,
  input wire [`PF_W-1:0] programmable_flag_pin_in,
  output wire [`IRQ_W-1:0] interrupt_seen,
  output wire flag_input_seen,
  output wire [`PF_W-1:0] programmable_flag_seen,
  // flag outputs from the core
  input wire [`PF_W-1:0] pf_out_value,
  input wire [`PF_W-1:0] pf_out_drive,
  input wire [`FL_W-1:0] fl_value,
  input wire flag_output_value,
  output wire [`PF_W-1:0] programmable_flag_pin_out,
  output wire [`PF_W-1:0] programmable_flag_pin_oe,
  output wire [`FL_W-1:0] dedicated_flag_out,
  output wire flag_output,
  // memory interface from the core
  input wire [`MS_W-1:0] core_select_n,
  input wire core_rd_n,
  input wire core_wr_n,
  input wire core_needs_bus,
  output wire core_stall,
  output wire [`MS_W-1:0] memory_space_select_n,
  output wire rd_n,
  output wire wr_n,
  output wire strobe_oe,
  // bus arbitration
  input wire bus_request_n,
  output wire bus_grant_n,
  output wire bus_grant_hang_n
);
  localparam [3:0] ST_OWN = 4'h1;
  localparam [3:0] ST_OFF = 4'h2;
  localparam [3:0] ST_GRANT = 4'h4;
  localparam [3:0] ST_BACK = 4'h8;

  // ref_clk already is the doubled processor cycle; the output is ref_clk divided by two,
  // a toggle marks each processor cycle's phase for the outside world
  reg clk_phase_q;
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) clk_phase_q <= 1'b0;
    else clk_phase_q <= ~clk_phase_q;
  end
  assign processor_clock_output = clk_phase_q;

  // lock counter: core stays quiet until multiplier has settled
  // counted in processor cycles, two to each input clock
  localparam integer LOCK_LAST = LOCK_CYCLES * `CYC_PER_INPUT_CLK - 1;
  reg [`LOCK_CNT_W-1:0] lock_q;
  reg lock_done_q;
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      lock_q <= {`LOCK_CNT_W{1'b0}};
      lock_done_q <= 1'b0;
    end else if (!lock_done_q) begin
      lock_q <= lock_q + {{(`LOCK_CNT_W-1){1'b0}}, 1'b1};
      if (lock_q >= LOCK_LAST[`LOCK_CNT_W-1:0])
        lock_done_q <= 1'b1;
    end
  end
  assign lock_done = lock_done_q;

  // straps caught on the first clock after release, not in the reset branch
  reg [`MODE_W-1:0] mode_q;
  reg mode_taken_q;
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_q <= `MODE_RESET_VAL;
      mode_taken_q <= 1'b0;
    end else if (!mode_taken_q) begin
      mode_q <= mode_select;
      mode_taken_q <= 1'b1;
    end
  end
  assign mode_latched = mode_q;

  // three-stage synchronisers; change counts when stages two and three agree
  localparam SW = `IRQ_W + 1 + `PF_W + 1;
  // stages start at the idle levels of their pins, so release shows no false change
  localparam [SW-1:0] SYNC_IDLE = {1'b1, {`PF_W{1'b0}}, 1'b0, {`IRQ_W{1'b1}}};
  wire [SW-1:0] async_in = {bus_request_n, programmable_flag_pin_in, flag_input,
                            external_interrupt_n};
  reg [SW-1:0] s1_q, s2_q, s3_q, seen_q;
  wire [SW-1:0] agree = ~(s2_q ^ s3_q);
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_q <= SYNC_IDLE;
      s2_q <= SYNC_IDLE;
      s3_q <= SYNC_IDLE;
      seen_q <= SYNC_IDLE;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      seen_q <= (agree & s3_q) | (~agree & seen_q);
    end
  end
  assign interrupt_seen = ~seen_q[`IRQ_W-1:0];
  assign flag_input_seen = seen_q[`IRQ_W];
  assign programmable_flag_seen = seen_q[`IRQ_W+`PF_W:`IRQ_W+1];
  wire req_seen = ~seen_q[SW-1];

  // flag outputs move only as the clock output goes low, otherwise hold
  // an edge taken while the clock output is high is the one that drops it
  wire processor_clock_output_falls = clk_phase_q;
  reg [`PF_W-1:0] pf_q, pf_oe_q;
  reg [`FL_W-1:0] fl_q;
  reg fo_q;
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pf_q <= {`PF_W{1'b0}};
      pf_oe_q <= {`PF_W{1'b0}};
      fl_q <= {`FL_W{1'b0}};
      fo_q <= 1'b0;
    end else if (processor_clock_output_falls) begin
      pf_q <= pf_out_value;
      pf_oe_q <= pf_out_drive;
      fl_q <= fl_value;
      fo_q <= flag_output_value;
    end
  end
  assign programmable_flag_pin_out = pf_q;
  assign programmable_flag_pin_oe = pf_oe_q;
  assign dedicated_flag_out = fl_q;
  assign flag_output = fo_q;

  // one-hot decode of the hand-over states, shared by several outputs
  function owns_bus;
    input [3:0] st;
    begin
      owns_bus = (st == ST_OWN);
    end
  endfunction
  function lent_out;
    input [3:0] st;
    begin
      lent_out = (st == ST_GRANT);
    end
  endfunction

  // arbitration: release strobes first, grant a cycle later; reverse on return
  // strobes only let go on an edge that raises the clock output, as outside logic expects
  wire processor_clock_output_rises = ~clk_phase_q;
  reg [3:0] st_q, st_d;
  always @* begin
    st_d = st_q;
    case (st_q)
      ST_OWN: begin
        if (req_seen && lock_done_q && processor_clock_output_rises) st_d = ST_OFF;
      end
      ST_OFF: st_d = ST_GRANT;
      ST_GRANT: begin
        if (!req_seen) st_d = ST_BACK;
      end
      ST_BACK: st_d = ST_OWN;
      default: st_d = ST_OWN;
    endcase
  end
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) st_q <= ST_OWN;
    else st_q <= st_d;
  end

  // selects and strobes trail the core by one cycle; strobe_oe says whether they are driven
  reg [`MS_W-1:0] ms_q;
  reg rd_q, wr_q;
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ms_q <= `MS_IDLE;
      rd_q <= 1'b1;
      wr_q <= 1'b1;
    end else begin
      ms_q <= core_select_n;
      rd_q <= core_rd_n;
      wr_q <= core_wr_n;
    end
  end
  assign memory_space_select_n = ms_q;
  assign rd_n = rd_q;
  assign wr_n = wr_q;

  // hang only inside grant, so strobes are already off and stay off
  reg oe_q, bg_q, bgh_q;
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      oe_q <= 1'b1;
      bg_q <= 1'b1;
      bgh_q <= 1'b1;
    end else begin
      oe_q <= owns_bus(st_d);
      bg_q <= ~lent_out(st_d);
      bgh_q <= ~(lent_out(st_d) && core_needs_bus);
    end
  end
  assign strobe_oe = oe_q;
  assign bus_grant_n = bg_q;
  assign bus_grant_hang_n = bgh_q;
  // core waits while the bus is lent out or the clock multiplier is still settling
  assign core_stall = ~oe_q | ~lock_done_q;
endmodule

// ### src/bus_grant_regs.vh
`ifndef BUS_GRANT_REGS_VH
`define BUS_GRANT_REGS_VH
// processor cycles per input clock period (cycle doubling)
`define CYC_PER_INPUT_CLK 2
// least reset low time, processor cycles
`define RESET_LOW_CYCLES 5
// lock wait, input clock cycles
`define LOCK_INPUT_CYCLES 2000
`define LOCK_CNT_W 13
`define MODE_W 4
`define MODE_RESET_VAL 4'h0
`define IRQ_W 6
`define PF_W 8
`define FL_W 3
`define MS_W 5
`define MS_IDLE 5'h1f
`endif
